// file: verilog/ptw_pkg.sv
// Constants, types and register layout of the periodic wake-up timer.
// Assumes a 32-bit APB master and oscillator levels synchronous to MCLK.
package ptw_pkg;

    // ==========================================================
    // Register offsets (byte addresses).
    localparam logic [7:0]  OFS_CTRL     = 8'h04;
    localparam logic [7:0]  OFS_STATUS   = 8'h08;
    localparam logic [7:0]  OFS_COUNT    = 8'h0C;
    localparam logic [7:0]  OFS_WSTAT    = 8'h10;
    localparam logic [7:0]  OFS_WREQ_EN  = 8'h14;
    localparam logic [7:0]  OFS_WRISE_EN = 8'h18;

    // ==========================================================
    // Reset values.
    localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
    localparam logic [2:0]  STAT_RESET   = 3'h0;
    localparam logic [31:0] WAKE_RESET   = 32'h0000_0000;

    // ==========================================================
    // Field positions.
    localparam int unsigned ST_PER_BIT   = 0;
    localparam int unsigned ST_LONG_BIT  = 1;
    localparam int unsigned ST_ROV_BIT   = 2;
    localparam int unsigned WK_PER_BIT   = 0;
    localparam int unsigned WK_LONG_BIT  = 1;
    localparam int unsigned WK_EXT_BASE  = 2;
    localparam int unsigned LONG_LO      = 10;
    localparam int unsigned LONG_W       = 12;
    localparam int unsigned PER_W        = 10;

    // ==========================================================
    // Prescaler ratios.
    localparam int unsigned PRESCALE_A   = 512;
    localparam int unsigned PRESCALE_B   = 32;

    // Counter clock source codes.
    typedef enum logic [1:0] {
        SRC_XTAL = 2'b00,
        SRC_SLOW = 2'b01,
        SRC_FAST = 2'b10,
        SRC_RSVD = 2'b11
    } ptw_src_e;

    // Control register layout, most significant field first.
    typedef struct packed {
        logic                counter_enable_bit;
        logic                long_alarm_irq_enable;
        logic                debug_freeze_enable;
        logic                rollover_enable;
        logic [LONG_W-1:0]   long_alarm_compare;
        logic                periodic_alarm_enable;
        logic                periodic_alarm_irq_enable;
        ptw_src_e            clock_source_select;
        logic                prescale_512_enable;
        logic                prescale_32_enable;
        logic [PER_W-1:0]    periodic_compare;
    } ptw_ctrl_s;

    // One-cycle timer events.
    typedef struct packed {
        logic rollover;
        logic long_alarm;
        logic periodic;
    } ptw_evt_s;

endpackage : ptw_pkg

// file: verilog/ptw_div.sv
// Tick prescaler that passes one tick in DIV, or all ticks when bypassed.
// Assumes tick_in is a one-cycle pulse in the MCLK domain.
`timescale 1ns/1ps
module ptw_div #(
    parameter int unsigned DIV = 512
) (
    // Clock, reset and freeze.
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic ce,
    // Tick path.
    input  wire logic bypass,
    input  wire logic tick_in,
    output logic      tick_out
);

    localparam int unsigned     CW   = $clog2(DIV);
    localparam logic [CW-1:0]   LAST = CW'(DIV - 1);

    // ==========================================================
    // Refuse ratios the counter cannot express.
    generate
        if (DIV < 2)
        begin : g_chk
            $error("ptw_div needs DIV of at least 2");
        end
    endgenerate

    logic [CW-1:0] cnt_r;
    logic          wrap;

    // Last input tick of each group of DIV.
    assign wrap     = tick_in & (cnt_r == LAST);
    assign tick_out = bypass ? tick_in : wrap;

    // Count input ticks while the divider is in the path.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            cnt_r <= '0;
        else if (ce && tick_in && !bypass)
            cnt_r <= wrap ? '0 : CW'(cnt_r + 1'b1);
    end

endmodule : ptw_div

// file: verilog/ptw_top.sv
// Periodic wake-up timer: free-running counter, long and periodic alarms,
// rollover, timer status and a small wake unit, all behind an APB slave.
// Assumes RST is the power-up reset and all inputs are synchronous to MCLK.
`timescale 1ns/1ps
module ptw_top
    import ptw_pkg::*;
#(
    parameter int unsigned ADDR_W = 8,
    parameter int unsigned N_EXT  = 2
) (
    // Clock, reset, clock enable.
    input  wire logic              MCLK,
    input  wire logic              RST,
    input  wire logic              CE,
    // APB slave.
    input  wire logic              PSEL,
    input  wire logic              PENABLE,
    input  wire logic              PWRITE,
    input  wire logic [ADDR_W-1:0] PADDR,
    input  wire logic [31:0]       PWDATA,
    input  wire logic [3:0]        PSTRB,
    output logic [31:0]            PRDATA,
    output logic                   PREADY,
    output logic                   PSLVERR,
    // Oscillator levels.
    input  wire logic              SLOW_XTAL_OSC,
    input  wire logic              SLOW_INT_OSC,
    input  wire logic              FAST_INT_OSC,
    // Debug state.
    input  wire logic              DEBUG_MODE,
    // External wake inputs.
    input  wire logic [N_EXT-1:0]  EXT_WAKE,
    // Wake and interrupt requests.
    output logic [1:0]             TIMER_WAKE,
    output logic                   WAKE_REQ,
    output logic                   LONG_IRQ,
    output logic                   PERIODIC_IRQ
);

    localparam int unsigned WK_W = N_EXT + WK_EXT_BASE;

    // ==========================================================
    // Elaboration checks.
    generate
        if (ADDR_W < 5 || ADDR_W > 32 || N_EXT < 1 || N_EXT > 30)
        begin : g_chk
            $error("ptw_top parameters out of range");
        end
    endgenerate

    // ==========================================================
    // Declarations.
    ptw_ctrl_s         ctrl_r, ctrl_nxt;
    logic [2:0]        stat_r, stat_nxt;
    logic [WK_W-1:0]   wstat_r, wstat_nxt, wreq_en_r, wrise_en_r;
    logic [WK_W-1:0]   wline, wline_prev_r, wrise;
    logic [31:0]       prdata_r, rd_val, mask, clr;
    logic              hit_ctrl, hit_stat, hit_cnt, hit_wstat, hit_wreq, hit_wrise;
    logic              mapped, wr, tmr_arst, tmr_rst;
    logic [1:0]        rsync_r;
    logic              src_lvl, src_prev_r, src_tick, tick_a, tick_b, cnt_tick;
    logic [31:0]       cnt_r, cnt_inc;
    logic [PER_W-1:0]  pv_s1_r, pv_s2_r, per_pt_r;
    logic              per_arm, per_act_r, per_hit, long_hit, rov_hit;
    ptw_evt_s          evt_r;
    logic [1:0]        tw_r;
    logic              wake_req_r, long_irq_r, per_irq_r;

    // ==========================================================
    // APB decode; a frozen clock enable stretches the access phase.
    assign hit_ctrl  = (PADDR == ADDR_W'(OFS_CTRL));
    assign hit_stat  = (PADDR == ADDR_W'(OFS_STATUS));
    assign hit_cnt   = (PADDR == ADDR_W'(OFS_COUNT));
    assign hit_wstat = (PADDR == ADDR_W'(OFS_WSTAT));
    assign hit_wreq  = (PADDR == ADDR_W'(OFS_WREQ_EN));
    assign hit_wrise = (PADDR == ADDR_W'(OFS_WRISE_EN));
    assign mapped    = hit_ctrl | hit_stat | hit_cnt | hit_wstat | hit_wreq | hit_wrise;
    assign wr        = PSEL & PENABLE & PWRITE & CE & mapped;
    assign PREADY    = CE;
    assign PSLVERR   = PSEL & PENABLE & ~mapped;
    assign PRDATA    = prdata_r;

    // Byte strobes widened to a bit mask; write-one-clear pattern.
    assign mask = {{8{PSTRB[3]}}, {8{PSTRB[2]}}, {8{PSTRB[1]}}, {8{PSTRB[0]}}};
    assign clr  = PWDATA & mask;

    // Read value of the addressed register; unmapped reads as zero.
    always_comb
    begin
        rd_val = 32'h0000_0000;
        if (hit_ctrl)
            rd_val = ctrl_r;
        else if (hit_stat)
            rd_val = {29'h0, stat_r};
        else if (hit_cnt)
            rd_val = cnt_r;
        else if (hit_wstat)
            rd_val = 32'(wstat_r);
        else if (hit_wreq)
            rd_val = 32'(wreq_en_r);
        else if (hit_wrise)
            rd_val = 32'(wrise_en_r);
    end

    // Read data is captured in the setup phase and held for the access.
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
            prdata_r <= 32'h0000_0000;
        else if (CE && PSEL && !PENABLE && !PWRITE)
            prdata_r <= rd_val;
    end

    // ==========================================================
    // Control register with byte-lane merge.
    assign ctrl_nxt = (ctrl_r & ~mask) | (PWDATA & mask);

    // Control register, cleared only by the power-up reset.
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
            ctrl_r <= CTRL_RESET;
        else if (wr && hit_ctrl)
            ctrl_r <= ctrl_nxt;
    end

    // Wake unit enable registers.
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            wreq_en_r  <= WK_W'(WAKE_RESET);
            wrise_en_r <= WK_W'(WAKE_RESET);
        end
        else if (wr)
        begin
            if (hit_wreq)
                wreq_en_r <= (wreq_en_r & ~WK_W'(mask)) | WK_W'(PWDATA & mask);
            if (hit_wrise)
                wrise_en_r <= (wrise_en_r & ~WK_W'(mask)) | WK_W'(PWDATA & mask);
        end
    end

    // ==========================================================
    // Timer reset: asserted at once by RST or a cleared enable,
    // released two clocks later so the counter logic leaves reset cleanly.
    assign tmr_arst = RST | ~ctrl_r.counter_enable_bit;

    // Release synchroniser for the timer reset.
    always_ff @(posedge MCLK or posedge tmr_arst)
    begin
        if (tmr_arst)
            rsync_r <= 2'b11;
        else if (CE)
            rsync_r <= {rsync_r[0], 1'b0};
    end

    // Only the power-up reset or a cleared enable resets the counter.
    assign tmr_rst = rsync_r[1];

    // ==========================================================
    // Counter clock source selection.
    always_comb
    begin
        unique case (ctrl_r.clock_source_select)
            SRC_XTAL: src_lvl = SLOW_XTAL_OSC;
            SRC_SLOW: src_lvl = SLOW_INT_OSC;
            SRC_FAST: src_lvl = FAST_INT_OSC;
            SRC_RSVD: src_lvl = 1'b0;
        endcase
    end

    // Rising edge of the selected oscillator makes one source tick.
    always_ff @(posedge MCLK or posedge tmr_rst)
    begin
        if (tmr_rst)
            src_prev_r <= 1'b0;
        else if (CE)
            src_prev_r <= src_lvl;
    end

    assign src_tick = src_lvl & ~src_prev_r;

    // Divide-by-512 stage, bypassed when its enable is clear.
    ptw_div #(
        .DIV (PRESCALE_A)
    ) u_div_a (
        .clk      (MCLK),
        .rst      (tmr_rst),
        .ce       (CE),
        .bypass   (~ctrl_r.prescale_512_enable),
        .tick_in  (src_tick),
        .tick_out (tick_a)
    );

    // Divide-by-32 stage, cascaded behind the first one.
    ptw_div #(
        .DIV (PRESCALE_B)
    ) u_div_b (
        .clk      (MCLK),
        .rst      (tmr_rst),
        .ce       (CE),
        .bypass   (~ctrl_r.prescale_32_enable),
        .tick_in  (tick_a),
        .tick_out (tick_b)
    );

    // Debug freeze withholds counter ticks so the count is held.
    assign cnt_tick = tick_b & ~(DEBUG_MODE & ctrl_r.debug_freeze_enable);

    // ==========================================================
    // Shared 32-bit free-running counter.
    assign cnt_inc = cnt_r + 32'h0000_0001;

    // Counter advances on each counter tick and wraps naturally.
    always_ff @(posedge MCLK or posedge tmr_rst)
    begin
        if (tmr_rst)
            cnt_r <= 32'h0000_0000;
        else if (CE && cnt_tick)
            cnt_r <= cnt_inc;
    end

    // ==========================================================
    // Periodic compare value carried over two counter ticks.
    always_ff @(posedge MCLK or posedge tmr_rst)
    begin
        if (tmr_rst)
        begin
            pv_s1_r <= '0;
            pv_s2_r <= '0;
        end
        else if (CE && cnt_tick)
        begin
            pv_s1_r <= ctrl_r.periodic_compare;
            pv_s2_r <= pv_s1_r;
        end
    end

    // Periodic function runs only when enabled with a nonzero value.
    assign per_arm = ctrl_r.periodic_alarm_enable & (pv_s2_r != '0);

    // Match on the low counter bits reaching the next compare point.
    assign per_hit = cnt_tick & per_act_r & per_arm & (cnt_inc[PER_W-1:0] == per_pt_r);

    // Compare point: seeded once armed, advanced by the value on each match.
    always_ff @(posedge MCLK or posedge tmr_rst)
    begin
        if (tmr_rst)
        begin
            per_act_r <= 1'b0;
            per_pt_r  <= '0;
        end
        else if (CE && cnt_tick)
        begin
            if (!per_arm)
                per_act_r <= 1'b0;
            else if (!per_act_r)
            begin
                per_act_r <= 1'b1;
                per_pt_r  <= PER_W'(cnt_r[PER_W-1:0] + pv_s2_r);
            end
            else if (per_hit)
                per_pt_r <= PER_W'(per_pt_r + pv_s2_r);
        end
    end

    // Long alarm when counter bits 21..10 enter the compare value.
    assign long_hit = cnt_tick
                    & (cnt_inc[LONG_LO+LONG_W-1:0] == {ctrl_r.long_alarm_compare, 10'h000});

    // Rollover from all ones to zero.
    assign rov_hit = cnt_tick & ctrl_r.rollover_enable & (&cnt_r);

    // Event pulses and the timer wake lines, straight from the match logic.
    always_ff @(posedge MCLK or posedge tmr_rst)
    begin
        if (tmr_rst)
        begin
            evt_r <= '0;
            tw_r  <= 2'b00;
        end
        else if (CE)
        begin
            evt_r <= '{rollover: rov_hit, long_alarm: long_hit, periodic: per_hit};
            tw_r  <= {long_hit | rov_hit, per_hit};
        end
    end

    assign TIMER_WAKE = tw_r;

    // ==========================================================
    // Timer status: hardware set wins over a write-one clear.
    always_comb
    begin
        stat_nxt = stat_r;
        if (wr && hit_stat)
            stat_nxt = stat_r & ~clr[2:0];
        stat_nxt[ST_PER_BIT]  = stat_nxt[ST_PER_BIT]  | evt_r.periodic;
        stat_nxt[ST_LONG_BIT] = stat_nxt[ST_LONG_BIT] | evt_r.long_alarm;
        stat_nxt[ST_ROV_BIT]  = stat_nxt[ST_ROV_BIT]  | evt_r.rollover;
    end

    // Timer status register.
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
            stat_r <= STAT_RESET;
        else if (CE)
            stat_r <= stat_nxt;
    end

    // ==========================================================
    // Wake unit: timer lines and external inputs flagged on rising edges.
    assign wline = {EXT_WAKE, tw_r[WK_LONG_BIT], tw_r[WK_PER_BIT]};
    assign wrise = wline & ~wline_prev_r;

    // Wake status: edge set wins over write-one clear, zero leaves flags.
    always_comb
    begin
        wstat_nxt = wstat_r;
        if (wr && hit_wstat)
            wstat_nxt = wstat_r & ~WK_W'(clr);
        wstat_nxt = wstat_nxt | (wrise & wrise_en_r);
    end

    // Wake flags, line history and the wake request.
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            wline_prev_r <= '0;
            wstat_r      <= WK_W'(WAKE_RESET);
            wake_req_r   <= 1'b0;
        end
        else if (CE)
        begin
            wline_prev_r <= wline;
            wstat_r      <= wstat_nxt;
            wake_req_r   <= |(wstat_nxt & wreq_en_r);
        end
    end

    assign WAKE_REQ = wake_req_r;

    // ==========================================================
    // Interrupts follow the status flags one clock after the wake request.
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            long_irq_r <= 1'b0;
            per_irq_r  <= 1'b0;
        end
        else if (CE)
        begin
            long_irq_r <= ctrl_r.long_alarm_irq_enable
                        & (stat_r[ST_LONG_BIT] | stat_r[ST_ROV_BIT]);
            per_irq_r  <= ctrl_r.periodic_alarm_irq_enable & stat_r[ST_PER_BIT];
        end
    end

    assign LONG_IRQ     = long_irq_r;
    assign PERIODIC_IRQ = per_irq_r;

endmodule : ptw_top

// file: tb/ptw_properties.sv
// Checker of the timer's request outputs against its control settings.
// Assumes it is bound to ptw_top and sees only that module's ports.
`timescale 1ns/1ps
module ptw_properties
    import ptw_pkg::*;
#(
    parameter int unsigned ADDR_W = 8
) (
    // Clock and reset.
    input wire logic              MCLK,
    input wire logic              RST,
    // APB write side.
    input wire logic              PSEL,
    input wire logic              PENABLE,
    input wire logic              PWRITE,
    input wire logic              PREADY,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [31:0]       PWDATA,
    input wire logic [3:0]        PSTRB,
    // Debug state and requests.
    input wire logic              DEBUG_MODE,
    input wire logic [1:0]        TIMER_WAKE,
    input wire logic              WAKE_REQ,
    input wire logic              LONG_IRQ,
    input wire logic              PERIODIC_IRQ
);
    // ==========================================================
    // Shadow copies of the control and wake request enable words.
    logic [31:0] ctrl_r;
    logic [31:0] wen_r;
    logic [31:0] msk;
    logic        wr;
    assign msk = {{8{PSTRB[3]}}, {8{PSTRB[2]}}, {8{PSTRB[1]}}, {8{PSTRB[0]}}};
    assign wr  = PSEL && PENABLE && PREADY && PWRITE;

    // A write lands at the access edge, merged by byte lane.
    always_ff @(posedge MCLK or posedge RST)
    begin
        if (RST)
        begin
            ctrl_r <= 32'h0000_0000;
            wen_r  <= 32'h0000_0000;
        end
        else if (wr && PADDR == OFS_CTRL)
            ctrl_r <= (ctrl_r & ~msk) | (PWDATA & msk);
        else if (wr && PADDR == OFS_WREQ_EN)
            wen_r <= (wen_r & ~msk) | (PWDATA & msk);
    end

    // ==========================================================
    // Properties.
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (RST);

    property p_long_gate;
        LONG_IRQ |-> ctrl_r[30] || $past(ctrl_r[30]);
    endproperty
    a_long_gate: assert property (p_long_gate) else $error("long irq while disabled");
    property p_per_gate;
        PERIODIC_IRQ |-> ctrl_r[14] || $past(ctrl_r[14]);
    endproperty
    a_per_gate: assert property (p_per_gate) else $error("periodic irq while disabled");
    property p_off_quiet;
        !ctrl_r[31] |-> TIMER_WAKE == 2'b00;
    endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("event with counter off");
    property p_freeze;
        (DEBUG_MODE && ctrl_r[29]) [*4] |-> TIMER_WAKE == 2'b00;
    endproperty
    a_freeze: assert property (p_freeze) else $error("event while frozen");
    property p_long_order;
        TIMER_WAKE[1] && ctrl_r[30] |-> ##2 LONG_IRQ;
    endproperty
    a_long_order: assert property (p_long_order) else $error("long irq not after wake");
    property p_per_order;
        TIMER_WAKE[0] && ctrl_r[14] |-> ##2 PERIODIC_IRQ;
    endproperty
    a_per_order: assert property (p_per_order) else $error("periodic irq not after wake");
    property p_wake_gate;
        WAKE_REQ |-> (wen_r | $past(wen_r)) != 32'h0000_0000;
    endproperty
    a_wake_gate: assert property (p_wake_gate) else $error("wake request not enabled");
    property p_per_off;
        !ctrl_r[15] [*4] |-> !TIMER_WAKE[0];
    endproperty
    a_per_off: assert property (p_per_off) else $error("periodic event while off");
    property p_per_zero;
        (ctrl_r[9:0] == 10'h000) [*4] |-> !TIMER_WAKE[0];
    endproperty
    a_per_zero: assert property (p_per_zero) else $error("periodic event at zero");
endmodule : ptw_properties

bind ptw_top ptw_properties #(.ADDR_W(ADDR_W)) ptw_properties_i (
    .MCLK(MCLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PREADY(PREADY), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB),
    .DEBUG_MODE(DEBUG_MODE), .TIMER_WAKE(TIMER_WAKE), .WAKE_REQ(WAKE_REQ),
    .LONG_IRQ(LONG_IRQ), .PERIODIC_IRQ(PERIODIC_IRQ)
);

// file: tb/ptw_far.sv
// Model of the wake unit's host side and the interrupt controller.
// Assumes the request lines are registered on the same clock.
`timescale 1ns/1ps
module ptw_far (
    // Clock and reset.
    input  wire logic clk,
    input  wire logic rst,
    // Long wake line, wake request and long interrupt.
    input  wire logic line_long,
    input  wire logic wake_req,
    input  wire logic long_irq,
    // Event counts for the bench.
    output int        n_wake,
    output int        n_irq,
    output int        n_ordered
);
    // ==========================================================
    // Rising edges are counted; an interrupt is ordered if a wake came first.
    logic line_r;
    logic req_r;
    logic irq_r;
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            line_r    <= 1'b0;
            req_r     <= 1'b0;
            irq_r     <= 1'b0;
            n_wake    <= 0;
            n_irq     <= 0;
            n_ordered <= 0;
        end
        else
        begin
            req_r <= wake_req;
            irq_r <= long_irq;
            if (line_long)
                line_r <= 1'b1;
            if (wake_req && !req_r)
                n_wake <= n_wake + 1;
            if (long_irq && !irq_r)
            begin
                n_irq     <= n_irq + 1;
                n_ordered <= n_ordered + int'(line_r);
                line_r    <= 1'b0;
            end
        end
    end
endmodule : ptw_far

// file: tb/tb.sv
// Self-checking bench of the periodic wake-up timer.
// Assumes ptw_top with default parameters and a 10 MHz clock.
`timescale 1ns/1ps
module tb;
    import ptw_pkg::*;
    // ==========================================================
    // Signals.
    logic        mclk = 1'b0, rst = 1'b1, ce = 1'b1, psel = 1'b0;
    logic        pen  = 1'b0, pwr = 1'b0, dbg = 1'b0;
    logic [7:0]  padr = 8'h00;
    logic [31:0] pwd  = 32'h0000_0000;
    logic [3:0]  pst  = 4'h0;
    logic [3:0]  oc   = 4'h0;
    logic [1:0]  ext  = 2'b00;
    logic [31:0] seed = 32'h0000_B1C9;
    logic [31:0] prdata, v, c, q;
    logic [1:0]  twake;
    logic        pready, pslverr, wreq, lirq, pirq, err;
    int          n_mismatch = 0, n_compared = 0, cyc = 0;

    // Clock, and oscillators of period 2, 8 and 16 clocks.
    always #50 mclk = ~mclk;
    always @(posedge mclk)
        oc <= oc + 4'h1;

    ptw_top ptw_top_i (
        .MCLK(mclk), .RST(rst), .CE(ce), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
        .PADDR(padr), .PWDATA(pwd), .PSTRB(pst), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .SLOW_XTAL_OSC(oc[3]), .SLOW_INT_OSC(oc[2]),
        .FAST_INT_OSC(oc[0]), .DEBUG_MODE(dbg), .EXT_WAKE(ext), .TIMER_WAKE(twake),
        .WAKE_REQ(wreq), .LONG_IRQ(lirq), .PERIODIC_IRQ(pirq)
    );
    ptw_far ptw_far_i (
        .clk(mclk), .rst(rst), .line_long(twake[1]), .wake_req(wreq),
        .long_irq(lirq), .n_wake(), .n_irq(), .n_ordered()
    );

    // ==========================================================
    // Helpers.
    function logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e)
        begin
            $display("mismatch at %0t: saw %h, expected %h", $time, s, e);
            n_mismatch++;
        end
    endtask : chk

    task automatic summarize();
        $display("compared %0d, mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : summarize

    // One APB transfer, held until ready is seen at an edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s, output logic [31:0] r);
        @(posedge mclk);
        psel <= 1'b1;
        pwr  <= w;
        padr <= a;
        pwd  <= d;
        pst  <= s;
        @(posedge mclk);
        pen <= 1'b1;
        do
            @(posedge mclk);
        while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
        apb(1'b1, a, d, s, q);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000, 4'h0, q);
        chk(q, e);
    endtask : rd

    // Time of the next periodic wake pulse, or -1 if none within lim.
    task automatic wpulse(input int lim, output int t);
        t = -1;
        for (int k = 0; k < lim && t < 0; k++)
        begin
            @(posedge mclk);
            if (twake[0] === 1'b1)
                t = int'($time);
        end
    endtask : wpulse

    // Periodic alarm on one source and prescaler setting; p is clocks per tick.
    task automatic per_run(input logic [1:0] src, input logic d5, input logic d3, input int p);
        int t0, t1, t2, lim;
        v = (p > 64) ? 32'd4 : 32'd4 + xs() % 32'd12;
        lim = (int'(v) + 4) * ((p > 0) ? p : 16) + 40;
        wr(OFS_CTRL, 32'h0000_0000);
        wr(OFS_CTRL, 32'h8000_C000 | {src, d5, d3, 10'h000} | v);
        wpulse(lim, t0);
        if (p == 0)
            chk(t0, -1);
        else
        begin
            wpulse(lim, t1);
            wpulse(lim, t2);
            chk(t1 - t0, int'(v) * p * 100);
            chk(t2 - t1, int'(v) * p * 100);
            chk(pirq, 1);
        end
        wr(OFS_CTRL, 32'h0000_0000);
        rd(OFS_COUNT, 32'h0000_0000);
        rd(OFS_STATUS, {31'h0, p != 0});
        wr(OFS_STATUS, 32'h0000_0000);
        rd(OFS_STATUS, {31'h0, p != 0});
        wr(OFS_STATUS, 32'h0000_0001);
        rd(OFS_STATUS, 32'h0000_0000);
    endtask : per_run

    // ==========================================================
    // Cycle limit.
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            n_mismatch++;
            summarize();
        end
    end

    // Main sequence.
    initial
    begin
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        for (int a = 4; a <= 24; a += 4)
            rd(a[7:0], 32'h0000_0000);
        rd(8'h1C, 32'h0000_0000);
        chk(err, 1);
        v = xs() & 32'h7FFF_FFFF;
        wr(OFS_CTRL, v);
        rd(OFS_CTRL, v);
        wr(OFS_CTRL, 32'h0000_00A5, 4'h1);
        rd(OFS_CTRL, {v[31:8], 8'hA5});
        wr(OFS_COUNT, 32'hFFFF_FFFF);
        rd(OFS_COUNT, 32'h0000_0000);
        per_run(SRC_FAST, 1'b0, 1'b0, 2);
        per_run(SRC_SLOW, 1'b0, 1'b0, 8);
        per_run(SRC_XTAL, 1'b0, 1'b0, 16);
        per_run(SRC_FAST, 1'b0, 1'b1, 64);
        per_run(SRC_FAST, 1'b1, 1'b0, 1024);
        per_run(SRC_RSVD, 1'b0, 1'b0, 0);
        // Debug freeze holds the count and stops periodic pulses, then resumes.
        wr(OFS_CTRL, 32'hA000_A004);
        repeat (20) @(posedge mclk);
        dbg <= 1'b1;
        repeat (4) @(posedge mclk);
        apb(1'b0, OFS_COUNT, 32'h0000_0000, 4'h0, c);
        repeat (30) @(posedge mclk);
        rd(OFS_COUNT, c);
        dbg <= 1'b0;
        repeat (20) @(posedge mclk);
        apb(1'b0, OFS_COUNT, 32'h0000_0000, 4'h0, q);
        chk(q > c, 1);
        wr(OFS_CTRL, 32'h0000_0000);
        // Long alarm at compare one; periodic on with zero value stays quiet.
        wr(OFS_WRISE_EN, 32'h0000_0006);
        wr(OFS_WREQ_EN, 32'h0000_0002);
        ext <= 2'b01;
        repeat (4) @(posedge mclk);
        rd(OFS_WSTAT, 32'h0000_0004);
        chk(wreq, 0);
        wr(OFS_CTRL, 32'hC001_A000);
        repeat (2040) @(posedge mclk);
        chk(lirq, 0);
        repeat (40) @(posedge mclk);
        chk(lirq, 1);
        chk(wreq, 1);
        rd(OFS_WSTAT, 32'h0000_0006);
        wr(OFS_WSTAT, 32'h0000_0000);
        rd(OFS_WSTAT, 32'h0000_0006);
        wr(OFS_WSTAT, 32'h0000_0002);
        rd(OFS_WSTAT, 32'h0000_0004);
        chk(wreq, 0);
        rd(OFS_STATUS, 32'h0000_0003);
        wr(OFS_STATUS, 32'h0000_0002);
        rd(OFS_STATUS, 32'h0000_0001);
        chk(lirq, 0);
        chk(ptw_far_i.n_wake, 1);
        chk(ptw_far_i.n_irq, 1);
        chk(ptw_far_i.n_ordered, 1);
        summarize();
    end
endmodule : tb
